// [hw/tmpc_consts.vh]
// Register map, field positions and reset values of the target-mode
// configuration bank. Assumes inclusion by bare name from hw/.
`ifndef TMPC_CONSTS_VH
`define TMPC_CONSTS_VH

// --------------------------------------------------------------------
// Register indices and address width
// --------------------------------------------------------------------
`define TMPC_IDX_SELSLOT 8'h1B
`define TMPC_IDX_TYPEA 8'h1C
`define TMPC_IDX_RCVTUNE 8'h1D
`define TMPC_IDX_STATUS 8'h1E
`define TMPC_ADDR_W 10

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define TMPC_RST_SELSLOT 8'h00
`define TMPC_RST_TYPEA 8'h62
`define TMPC_RST_RCVTUNE 8'h00

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define TMPC_BIT_HOLD_SEL 7
`define TMPC_BIT_HALF_SLOT 6
`define TMPC_BIT_HALT 2
`define TMPC_BIT_FAST_FILT 6
`define TMPC_BIT_OUT_DELAY 5
`define TMPC_BIT_PAR_OFF 4
`define TMPC_BIT_WIDE_PLL 3
`define TMPC_BIT_HP_MANUAL 2

// --------------------------------------------------------------------
// Protocol constants
// --------------------------------------------------------------------
`define TMPC_REQ_WAKE 8'h52
`define TMPC_EXTRA_BITS_BASE 4'h7
`define TMPC_HP_106 2'b00
`define TMPC_HP_212 2'b01
`define TMPC_HP_424 2'b10
`define TMPC_RX_106 2'b00
`define TMPC_RX_212 2'b01
`define TMPC_RX_424 2'b10

`endif

// [hw/tmpc_halt_flag.v]
// Halt flag keeper: host writes, protocol set, field reset clear.
// Assumes all event inputs are synchronous one-cycle pulses on hclk.
`timescale 1ns/1ps
`default_nettype none

module tmpc_halt_flag (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire host_wr,
  input wire host_val,
  input wire proto_set,
  input wire field_reset,
  output reg halt_ff
);

  reg nxt_halt;

  // --------------------------------------------------------------------
  // Next value: field reset clears, then hardware set, then host write
  // --------------------------------------------------------------------
  always @* begin
    nxt_halt = halt_ff;
    if (host_wr) begin
      nxt_halt = host_val;
    end
    if (proto_set) begin
      nxt_halt = 1'b1; // Set beats host clear
    end
    if (field_reset) begin
      nxt_halt = 1'b0; // RF reset clears
    end
  end

  // Flag register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_ff <= 1'b0;
    end else if (clk_en) begin
      halt_ff <= nxt_halt;
    end
  end

endmodule

`default_nettype wire

// [hw/tmpc_top.v]
// Target-mode protocol configuration bank with AHB-Lite register slave.
// Assumes a single AHB-Lite master, single word transfers, one hclk.
//
// Functional notes
// - Hold selected: end autocoll only after select or polling
// - Hold selected blocks active communication
// - Half slot bit halves 424 kbit passive slot
// - Halted at 106 kbit: accept only 52h
// - Halt set by host/protocol, field reset clears
// - Extra response time adds seven to ten bit periods
// - Parity off: no parity generate or check
// - Manual override chooses corner field else mode
// - Corner codes 106, 212, 424 kHz
// - Fast Miller filter bit selects fast mode
// - Output delay bit delays signal output pin
// - Wide PLL bit extends clock recovery bandwidth
// - Miller sensitivity field bits seven to five
// - Miller time constant field bits four to three
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmpc_consts.vh"

module tmpc_top #(
  parameter ADDR_W = `TMPC_ADDR_W
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Protocol engine events and status
  input wire [1:0] rx_mode,
  input wire passive_mode,
  input wire card_106,
  input wire autocoll_active,
  input wire select_done,
  input wire polling_done,
  input wire valid_cmd,
  input wire req_valid,
  input wire [7:0] req_code,
  input wire proto_halt_set,
  input wire field_reset,
  input wire active_req,
  // Configuration and decisions to the analog and framing logic
  output reg autocoll_end,
  output reg active_allowed,
  output reg half_slot_select,
  output reg req_accept,
  output reg [3:0] target_response_extra_bits,
  output reg parity_gen_en,
  output reg parity_check_en,
  output reg [1:0] highpass_corner,
  output reg fast_miller_filter,
  output reg output_signal_delay,
  output reg wide_pll_bandwidth,
  output reg [2:0] miller_sensitivity,
  output reg [1:0] miller_time_constant
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Word index from byte address
  function [7:0] word_idx;
    input [ADDR_W-1:0] a;
    begin
      word_idx = a[9:2];
    end
  endfunction

  // Automatic corner from the receive mode
  function [1:0] auto_corner;
    input [1:0] mode;
    begin
      case (mode)
        `TMPC_RX_212: auto_corner = `TMPC_HP_212;
        `TMPC_RX_424: auto_corner = `TMPC_HP_424;
        default: auto_corner = `TMPC_HP_106;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [7:0] selslot_ff;
  reg [7:0] typea_ff;
  reg [7:0] rcvtune_ff;
  reg wr_pend_ff;
  reg [7:0] wr_idx_ff;
  reg armed_ff;
  reg [7:0] nxt_selslot;
  reg [7:0] nxt_typea;
  reg [7:0] nxt_rcvtune;
  reg [31:0] nxt_rdata;
  reg nxt_armed;
  wire halt_flag;
  wire halt_next;
  wire addr_ok;
  wire [7:0] a_idx;
  wire wr_typea;

  // Address phase qualifier
  assign addr_ok = hsel & hready & htrans[1];
  assign a_idx = word_idx(haddr[ADDR_W-1:0]);
  assign wr_typea = wr_pend_ff & (wr_idx_ff == `TMPC_IDX_TYPEA);
  // Halt value after this edge, so a back-to-back read sees it
  assign halt_next = field_reset ? 1'b0 : (proto_halt_set ? 1'b1 :
    (wr_typea ? hwdata[`TMPC_BIT_HALT] : halt_flag));

  // --------------------------------------------------------------------
  // Halt flag
  // --------------------------------------------------------------------
  tmpc_halt_flag u_halt (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .host_wr(wr_typea),
    .host_val(hwdata[`TMPC_BIT_HALT]),
    .proto_set(proto_halt_set),
    .field_reset(field_reset),
    .halt_ff(halt_flag)
  );

  // --------------------------------------------------------------------
  // Register write data phase
  // --------------------------------------------------------------------
  always @* begin
    nxt_selslot = selslot_ff;
    nxt_typea = typea_ff;
    nxt_rcvtune = rcvtune_ff;
    if (wr_pend_ff) begin
      case (wr_idx_ff)
        `TMPC_IDX_SELSLOT: nxt_selslot = hwdata[7:0];
        `TMPC_IDX_TYPEA: nxt_typea = hwdata[7:0];
        `TMPC_IDX_RCVTUNE: nxt_rcvtune = hwdata[7:0];
        default: nxt_selslot = selslot_ff;
      endcase
    end
  end

  // Read data, presented in the data phase of a read
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (a_idx)
      `TMPC_IDX_SELSLOT: nxt_rdata[7:0] = nxt_selslot; // Write forwarded
      `TMPC_IDX_TYPEA: begin
        nxt_rdata[7:0] = nxt_typea;
        nxt_rdata[`TMPC_BIT_HALT] = halt_next; // Live flag
      end
      `TMPC_IDX_RCVTUNE: nxt_rdata[7:0] = nxt_rcvtune;
      `TMPC_IDX_STATUS: begin
        nxt_rdata[0] = armed_ff;
        nxt_rdata[1] = halt_next;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Bus registers; zero wait state, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      selslot_ff <= `TMPC_RST_SELSLOT;
      typea_ff <= `TMPC_RST_TYPEA;
      rcvtune_ff <= `TMPC_RST_RCVTUNE;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      selslot_ff <= nxt_selslot;
      typea_ff <= nxt_typea;
      rcvtune_ff <= nxt_rcvtune;
      wr_pend_ff <= addr_ok & hwrite;
      wr_idx_ff <= a_idx;
      if (addr_ok & ~hwrite) begin
        hrdata <= nxt_rdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Autocoll completion tracking
  // --------------------------------------------------------------------
  // Armed after a completed select or polling; cleared by field reset in a cycle without either
  always @* begin
    nxt_armed = armed_ff;
    if (!autocoll_active || field_reset) begin
      nxt_armed = 1'b0;
    end
    if (autocoll_active && (select_done || polling_done)) begin
      nxt_armed = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_ff <= 1'b0;
    end else if (clk_en) begin
      armed_ff <= nxt_armed;
    end
  end

  // --------------------------------------------------------------------
  // Registered decisions and configuration outputs
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      autocoll_end <= 1'b0;
      active_allowed <= 1'b0;
      half_slot_select <= 1'b0;
      req_accept <= 1'b0;
      target_response_extra_bits <= 4'h0;
      parity_gen_en <= 1'b1;
      parity_check_en <= 1'b1;
      highpass_corner <= `TMPC_HP_106;
      fast_miller_filter <= 1'b0;
      output_signal_delay <= 1'b0;
      wide_pll_bandwidth <= 1'b0;
      miller_sensitivity <= 3'h0;
      miller_time_constant <= 2'h0;
    end else if (clk_en) begin
      // Autocoll end: any valid command, or only after select or polling
      if (selslot_ff[`TMPC_BIT_HOLD_SEL]) begin
        autocoll_end <= autocoll_active & valid_cmd & armed_ff;
      end else begin
        autocoll_end <= autocoll_active & valid_cmd;
      end
      // Active requests blocked while holding for select
      active_allowed <= active_req &
        ~selslot_ff[`TMPC_BIT_HOLD_SEL];
      // Half slot only meaningful at 424 kbit passive
      half_slot_select <= selslot_ff[`TMPC_BIT_HALF_SLOT] &
        passive_mode & (rx_mode == `TMPC_RX_424);
      // Halted card at 106 kbit accepts only the wake request
      if (halt_flag && card_106) begin
        req_accept <= req_valid &
          (req_code == `TMPC_REQ_WAKE);
      end else begin
        req_accept <= req_valid;
      end
      target_response_extra_bits <= `TMPC_EXTRA_BITS_BASE +
        {2'b00, typea_ff[1:0]};
      parity_gen_en <= ~rcvtune_ff[`TMPC_BIT_PAR_OFF];
      parity_check_en <= ~rcvtune_ff[`TMPC_BIT_PAR_OFF];
      if (rcvtune_ff[`TMPC_BIT_HP_MANUAL]) begin
        highpass_corner <= rcvtune_ff[1:0];
      end else begin
        highpass_corner <= auto_corner(rx_mode);
      end
      fast_miller_filter <= rcvtune_ff[`TMPC_BIT_FAST_FILT];
      output_signal_delay <= rcvtune_ff[`TMPC_BIT_OUT_DELAY];
      wide_pll_bandwidth <= rcvtune_ff[`TMPC_BIT_WIDE_PLL];
      miller_sensitivity <= typea_ff[7:5];
      miller_time_constant <= typea_ff[4:3];
    end
  end

endmodule

`default_nettype wire

// [tb/tmpc_top_asserts.sv]
// Port checker for the target-mode configuration bank.
// Assumes binding into tmpc_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tmpc_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic valid_cmd,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic proto_halt_set,
  input wire logic field_reset,
  input wire logic autocoll_end,
  input wire logic req_accept,
  input wire logic [3:0] target_response_extra_bits,
  input wire logic parity_gen_en,
  input wire logic parity_check_en,
  input wire logic [2:0] miller_sensitivity,
  input wire logic [1:0] highpass_corner
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Bus and decision relations
  // ----------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_parity_pair: assert property (parity_gen_en == parity_check_en)
    else $error("parity enables disagree");
  a_extra_range: assert property (
    $past(hresetn) |-> target_response_extra_bits inside {[4'h7:4'ha]})
    else $error("extra response bits out of range");
  a_accept_cause: assert property (
    req_accept && $past(clk_en) |-> $past(req_valid))
    else $error("accept without request");
  a_wake_accept: assert property (
    req_valid && clk_en && req_code == 8'h52 |=> req_accept)
    else $error("wake request not accepted");
  a_halt_cleared: assert property (
    field_reset && clk_en ##1 req_valid && clk_en && !proto_halt_set
    |=> req_accept)
    else $error("request refused after field reset");
  a_coll_cause: assert property (
    autocoll_end && $past(clk_en) |-> $past(valid_cmd))
    else $error("autocoll ended without command");
  a_freeze_cfg: assert property (!clk_en |=>
    $stable(target_response_extra_bits) && $stable(miller_sensitivity) &&
    $stable(highpass_corner))
    else $error("config changed while frozen");
endmodule
bind tmpc_top tmpc_top_asserts chk_u (.hclk, .hresetn, .clk_en, .hrdata,
  .hreadyout, .hresp, .valid_cmd, .req_valid, .req_code, .proto_halt_set,
  .field_reset, .autocoll_end, .req_accept, .target_response_extra_bits,
  .parity_gen_en, .parity_check_en, .miller_sensitivity, .highpass_corner);
`default_nettype wire

// [tb/tmpc_rf_peer.sv]
// Model of the RF reader and its protocol events as seen by the bank.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tmpc_rf_peer (
  input wire logic hclk,
  output logic [1:0] rx_mode,
  output logic passive_mode,
  output logic card_106,
  output logic autocoll_active,
  output logic active_req,
  output logic select_done,
  output logic polling_done,
  output logic valid_cmd,
  output logic req_valid,
  output logic [7:0] req_code,
  output logic proto_halt_set,
  output logic field_reset
);
  // Idle levels at time zero
  initial begin
    {rx_mode, passive_mode, card_106, autocoll_active, active_req} = 0;
    {select_done, polling_done, valid_cmd, proto_halt_set} = 0;
    {field_reset, req_valid, req_code} = 0;
  end
  // Levels: receive mode, passive, card at 106, autocoll, active request
  task automatic levels(input logic [5:0] v);
    {rx_mode, passive_mode, card_106, autocoll_active, active_req} <= v;
  endtask
  // One-cycle events: select, polling, command, halt, field reset
  task automatic pulse(input logic [4:0] m);
    {select_done, polling_done, valid_cmd, proto_halt_set, field_reset} <= m;
    @(posedge hclk);
    {select_done, polling_done, valid_cmd, proto_halt_set, field_reset} <= 0;
  endtask
  // Request frame; code inverted once released
  task automatic send(input logic [7:0] c);
    req_valid <= 1'b1;
    req_code <= c;
    @(posedge hclk);
    req_valid <= 1'b0;
    req_code <= ~c;
  endtask
endmodule
`default_nettype wire

// [tb/tmpc_top_test.sv]
// Self-checking bench for the target-mode configuration bank.
// Assumes zero-wait AHB-Lite slave and registered outputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module tmpc_top_test;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 1, hwrite = 0;
  logic [2:0] hsize = 3'b010;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic hreadyout, hresp, autocoll_end, active_allowed, half_slot_select;
  logic req_accept, parity_gen_en, parity_check_en, fast_miller_filter;
  logic output_signal_delay, wide_pll_bandwidth;
  logic [3:0] target_response_extra_bits;
  logic [2:0] miller_sensitivity;
  logic [1:0] highpass_corner, miller_time_constant, rx_mode;
  logic passive_mode, card_106, autocoll_active, select_done, polling_done;
  logic valid_cmd, req_valid, proto_halt_set, field_reset, active_req;
  logic [7:0] req_code;
  int n_errors = 0, total_checks = 0;
  tmpc_top dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rx_mode, .passive_mode, .card_106, .autocoll_active, .select_done,
    .polling_done, .valid_cmd, .req_valid, .req_code, .proto_halt_set,
    .field_reset, .active_req, .autocoll_end, .active_allowed,
    .half_slot_select, .req_accept, .target_response_extra_bits,
    .parity_gen_en, .parity_check_en, .highpass_corner, .fast_miller_filter,
    .output_signal_delay, .wide_pll_bandwidth, .miller_sensitivity,
    .miller_time_constant);
  tmpc_rf_peer peer_u (.hclk, .rx_mode, .passive_mode, .card_106,
    .autocoll_active, .active_req, .select_done, .polling_done, .valid_cmd,
    .req_valid, .req_code, .proto_halt_set, .field_reset);
  // 250 MHz clock
  initial forever #2 hclk = ~hclk;
  // One single AHB-Lite transfer
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task automatic final_report;
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    #40000;
    n_errors++;
    final_report;
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h0000_006c, 32'h0000_0000);
    rchk(32'h0000_0070, 32'h0000_0062);
    rchk(32'h0000_0074, 32'h0000_0000);
    `CHK(target_response_extra_bits, 4'h9)
    `CHK(miller_sensitivity, 3'h3)
    bus(1'b1, 32'h0000_0080, 32'h0000_00ff);
    rchk(32'h0000_0080, 32'h0000_0000);
    bus(1'b1, 32'h0000_0070, 32'h0000_00fb);
    rchk(32'h0000_0070, 32'h0000_00fb);
    `CHK(miller_sensitivity, 3'h7)
    `CHK(miller_time_constant, 2'h3)
    `CHK(target_response_extra_bits, 4'ha)
    // Halted card at 106 kbit
    peer_u.levels(6'b00_0100);
    bus(1'b1, 32'h0000_0070, 32'h0000_0006);
    peer_u.send(8'h26);
    @(posedge hclk);
    `CHK(req_accept, 1'b0)
    peer_u.send(8'h52);
    @(posedge hclk);
    `CHK(req_accept, 1'b1)
    // Field reset clears halt, the very next request is accepted
    peer_u.pulse(5'b00001);
    peer_u.send(8'h26);
    @(posedge hclk);
    `CHK(req_accept, 1'b1)
    rchk(32'h0000_0070, 32'h0000_0002);
    peer_u.pulse(5'b00010);
    rchk(32'h0000_0070, 32'h0000_0006);
    peer_u.send(8'h26);
    @(posedge hclk);
    `CHK(req_accept, 1'b0)
    // Receiver tuning, reserved bit kept zero
    bus(1'b1, 32'h0000_0074, 32'h0000_007e);
    rchk(32'h0000_0074, 32'h0000_007e);
    `CHK(fast_miller_filter, 1'b1)
    `CHK(output_signal_delay, 1'b1)
    `CHK({parity_gen_en, parity_check_en}, 2'b00)
    `CHK(wide_pll_bandwidth, 1'b1)
    `CHK(highpass_corner, 2'b10)
    peer_u.levels(6'b01_0100);
    bus(1'b1, 32'h0000_0074, 32'h0000_0002);
    rchk(32'h0000_0074, 32'h0000_0002);
    `CHK(highpass_corner, 2'b01)
    // Frozen clock enable holds the corner across a mode change
    clk_en <= 1'b0;
    peer_u.levels(6'b10_0100);
    repeat (2) @(posedge hclk);
    `CHK(highpass_corner, 2'b01)
    clk_en <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(highpass_corner, 2'b10)
    // Hold until selected and short slot
    peer_u.levels(6'b10_1111);
    bus(1'b1, 32'h0000_006c, 32'h0000_00c0);
    rchk(32'h0000_006c, 32'h0000_00c0);
    `CHK(half_slot_select, 1'b1)
    `CHK(active_allowed, 1'b0)
    peer_u.pulse(5'b00100);
    @(posedge hclk);
    `CHK(autocoll_end, 1'b0)
    peer_u.pulse(5'b10000);
    @(posedge hclk);
    peer_u.pulse(5'b00100);
    @(posedge hclk);
    `CHK(autocoll_end, 1'b1)
    // Field reset disarms, a polling procedure arms again
    peer_u.pulse(5'b00001);
    @(posedge hclk);
    peer_u.pulse(5'b00100);
    @(posedge hclk);
    `CHK(autocoll_end, 1'b0)
    peer_u.pulse(5'b01000);
    @(posedge hclk);
    peer_u.pulse(5'b00100);
    @(posedge hclk);
    `CHK(autocoll_end, 1'b1)
    rchk(32'h0000_0078, 32'h0000_0001);
    bus(1'b1, 32'h0000_006c, 32'h0000_0000);
    rchk(32'h0000_006c, 32'h0000_0000);
    `CHK(half_slot_select, 1'b0)
    `CHK(active_allowed, 1'b1)
    final_report;
  end
endmodule
`default_nettype wire
